// ==== acc_channel_config.sv ====
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module acc_channel_config #(
  parameter int NCH = acc_pkg::NUM_CHAN,
  parameter logic [15:0] DWELL_CYCLES = acc_pkg::DWELL_DEFAULT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [15:0] rd_data,
  output logic rd_error,
  output acc_pkg::acc_route_t route,
  output logic [3:0] setup_onehot,
  output logic conv_start,
  output logic active
);
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_DWELL = 3'b010,
    ACC_STEP = 3'b100
  } acc_state_t;

  function automatic logic code_valid(input logic [4:0] code);
    code_valid = (code <= acc_pkg::INPUT_CODE_LAST) ||
                 (code >= acc_pkg::INPUT_CODE_TEMP_P && code <= acc_pkg::INPUT_CODE_REF_N);
  endfunction

  function automatic logic [3:0] setup_decode(input logic [1:0] sel);
    setup_decode = 4'h1 << sel;
  endfunction

  acc_pkg::acc_chan_word_t chan_ff [NCH];
  logic [15:0] rd_data_ff;
  logic rd_error_ff;
  logic [1:0] route_channel_ff;
  logic [1:0] route_setup_ff;
  logic [4:0] route_positive_ff;
  logic [4:0] route_negative_ff;
  logic route_pos_ok_ff;
  logic route_neg_ok_ff;
  logic [3:0] setup_onehot_ff;
  logic conv_start_ff;
  logic active_ff;
  acc_state_t state_ff;
  acc_state_t nxt_state;
  logic [1:0] cur_ff;
  logic [1:0] nxt_cur;
  logic [15:0] dwell_ff;
  logic [15:0] nxt_dwell;
  logic [15:0] nxt_rd_data;
  logic nxt_rd_error;

  wire logic in_chan_range = (addr >= acc_pkg::CHAN_BASE_ADDR) && (addr <= acc_pkg::CHAN_LAST_ADDR);
  wire logic [1:0] chan_index = 2'(addr - acc_pkg::CHAN_BASE_ADDR);
  wire logic wr_chan = wr_strobe && in_chan_range;
  wire logic [NCH-1:0] enables;
  wire logic [1:0] pick_next;
  wire logic any_en;
  wire logic [1:0] cur_setup = chan_ff[cur_ff].setup_choice;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      localparam logic [15:0] RST = (gi == 0) ? acc_pkg::CHAN_ZERO_RESET : acc_pkg::CHAN_OTHER_RESET;
      assign enables[gi] = chan_ff[gi].enable;
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          chan_ff[gi] <= RST;
        end else if (wr_chan && chan_index == 2'(gi)) begin
          // reserved bits masked so they always read zero; any code is stored
          chan_ff[gi] <= wr_data & acc_pkg::WRITABLE_MASK;
        end
      end
    end
  endgenerate

  acc_seq_picker #(
    .NCH(NCH)
  ) u_picker (
    .enables(enables),
    .current(cur_ff),
    .next_chan(pick_next),
    .any_enabled(any_en)
  );

  // read decode: exactly one class of address per read strobe
  wire logic rd_chan = rd_strobe && in_chan_range;
  wire logic rd_status = rd_strobe && (addr == acc_pkg::SEQ_STATUS_ADDR);
  wire logic rd_ctrl = rd_strobe && (addr == acc_pkg::SEQ_CTRL_ADDR);
  wire logic rd_miss = rd_strobe && !rd_chan && !rd_status && !rd_ctrl;
  wire logic [15:0] chan_word = chan_ff[chan_index];
  wire logic [15:0] status_word = {10'h000, active_ff, route_pos_ok_ff, route_neg_ok_ff, 1'b0, cur_ff};

  // register read path, data one cycle after the strobe
  always_comb begin
    nxt_rd_data = 16'h0000;
    nxt_rd_error = 1'b0;
    if (rd_chan) begin
      nxt_rd_data = chan_word;
    end else if (rd_status) begin
      nxt_rd_data = status_word;
    end else if (rd_ctrl) begin
      nxt_rd_data = dwell_ff;
    end else if (rd_miss) begin
      nxt_rd_error = 1'b1;
    end
  end

  // sequencer: dwell on each enabled channel, then step to the next one
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_dwell = dwell_ff;
    case (state_ff)
      ACC_IDLE: begin
        if (any_en) begin
          nxt_cur = enables[cur_ff] ? cur_ff : pick_next;
          nxt_dwell = DWELL_CYCLES;
          nxt_state = ACC_DWELL;
        end
      end
      ACC_DWELL: begin
        if (!any_en) begin
          nxt_state = ACC_IDLE;
        end else if (!enables[cur_ff]) begin
          nxt_state = ACC_STEP; // channel disabled mid-dwell, move on
        end else if (dwell_ff <= 16'h0001) begin
          nxt_state = ACC_STEP;
        end else begin
          nxt_dwell = dwell_ff - 16'h0001;
        end
      end
      ACC_STEP: begin
        // single enabled channel simply repeats itself
        nxt_cur = pick_next;
        nxt_dwell = DWELL_CYCLES;
        nxt_state = any_en ? ACC_DWELL : ACC_IDLE;
      end
      default: begin
        nxt_state = ACC_IDLE;
      end
    endcase
  end

  wire logic starting = (nxt_state == ACC_DWELL) && (state_ff != ACC_DWELL);
  wire logic seq_ctrl_wr = wr_strobe && (addr == acc_pkg::SEQ_CTRL_ADDR);
  wire logic dwelling = (state_ff == ACC_DWELL);
  // a host write to the dwell register overrides the live count
  wire logic [15:0] dwell_load = seq_ctrl_wr ? wr_data : nxt_dwell;
  wire acc_pkg::acc_chan_word_t cur_word = chan_ff[cur_ff];
  wire logic [4:0] cur_positive = cur_word.positive_choice;
  wire logic [4:0] cur_negative = cur_word.negative_choice;
  wire logic cur_pos_ok = code_valid(cur_positive);
  wire logic cur_neg_ok = code_valid(cur_negative);
  // setup choice picks the bundle of four registers
  wire logic [3:0] setup_pick = dwelling ? setup_decode(cur_setup) : 4'h0;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ACC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= 2'h0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dwell_ff <= 16'h0000;
    end else begin
      dwell_ff <= dwell_load;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_error_ff <= 1'b0;
    end else begin
      rd_error_ff <= nxt_rd_error;
    end
  end

  // routing of the channel in use, one cycle behind the current channel
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_channel_ff <= 2'h0;
    end else begin
      route_channel_ff <= cur_ff;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_setup_ff <= 2'h0;
    end else begin
      route_setup_ff <= cur_setup;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_positive_ff <= 5'h00;
    end else begin
      route_positive_ff <= cur_positive;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_negative_ff <= 5'h00;
    end else begin
      route_negative_ff <= cur_negative;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_pos_ok_ff <= 1'b0;
    end else begin
      route_pos_ok_ff <= cur_pos_ok;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_neg_ok_ff <= 1'b0;
    end else begin
      route_neg_ok_ff <= cur_neg_ok;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      setup_onehot_ff <= 4'h0;
    end else begin
      setup_onehot_ff <= setup_pick;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= starting;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= dwelling;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_error = rd_error_ff;
  assign route = {route_channel_ff, route_setup_ff, route_positive_ff, route_negative_ff, route_pos_ok_ff,
                  route_neg_ok_ff};
  assign setup_onehot = setup_onehot_ff;
  assign conv_start = conv_start_ff;
  assign active = active_ff;
endmodule

// ==== acc_channel_config_props.sv ====
`timescale 1ns/1ps
module acc_channel_config_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [15:0] rd_data,
  input wire logic rd_error,
  input wire acc_pkg::acc_route_t route,
  input wire logic [3:0] setup_onehot,
  input wire logic conv_start,
  input wire logic active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire chan = addr[7:2] == 6'h04;
  sequence s_bad_rd; rd_strobe && !chan && addr[7:1] != 7'h18; endsequence
  property p_rsvd; rd_strobe && chan |=> rd_data[14] == 1'b0 && rd_data[11:10] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("rsvd set");
  property p_bad; s_bad_rd |=> rd_error && rd_data == 16'h0000; endproperty
  a_bad: assert property (p_bad) else $error("no rd error");
  property p_ok; rd_strobe && chan |=> !rd_error; endproperty
  a_ok: assert property (p_ok) else $error("bad rd error");
  property p_quiet; !rd_strobe |=> rd_data == 16'h0000 && !rd_error; endproperty
  a_quiet: assert property (p_quiet) else $error("bus not quiet");
  property p_store;
    logic [15:0] d;
    (wr_strobe && addr == 8'h10, d = wr_data & acc_pkg::WRITABLE_MASK)
      ##1 !wr_strobe ##1 (rd_strobe && addr == 8'h10) |=> rd_data == d;
  endproperty
  a_store: assert property (p_store) else $error("readback");
  property p_one; $onehot0(setup_onehot) && (active || setup_onehot == 4'h0); endproperty
  a_one: assert property (p_one) else $error("setup select");
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start width");
  property p_pv;
    $past(reset_n) |-> route.pos_valid == (route.positive <= 5'h04 || route.positive inside {[5'h11:5'h16]});
  endproperty
  a_pv: assert property (p_pv) else $error("pos valid");
endmodule
bind acc_channel_config acc_channel_config_props i_props (.clock, .reset_n, .addr, .wr_data, .wr_strobe,
  .rd_strobe, .rd_data, .rd_error, .route, .setup_onehot, .conv_start, .active);

// ==== acc_channel_config_test.sv ====
`timescale 1ns/1ps
module acc_channel_config_test;
  logic clock, reset_n, wr_strobe, rd_strobe, rd_error, conv_start, active;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data;
  logic [3:0] setup_onehot;
  acc_pkg::acc_route_t route;
  int bad_count, samples_checked, cycles;
  // short dwell keeps the sequencing scenarios brief
  acc_channel_config #(.DWELL_CYCLES(16'h0004)) i_dut (.clock, .reset_n, .addr, .wr_data, .wr_strobe,
    .rd_strobe, .rd_data, .rd_error, .route, .setup_onehot, .conv_start, .active);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask
  task rd(logic [7:0] a, logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    chk("read", e, rd_data);
  endtask
  // waits for a dwell start, then lets route settle
  task wstart;
    @(posedge clock);
    #1;
    for (int n = 0; n < 60 && conv_start !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk("start", 16'h0001, {15'h0000, conv_start});
    repeat (2) @(posedge clock);
    #1;
  endtask
  task t_reset;
    rd(8'h10, 16'h8001);
    for (int i = 1; i < 4; i++) rd(8'h10 + 8'(i), 16'h0001);
    rd(8'h20, 16'h0000);
    chk("rd_error", 16'h0001, {15'h0000, rd_error});
    $display("reset test done");
  endtask
  task t_fields;
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'hb3ff);
    for (int s = 0; s < 4; s++) begin
      wr(8'h10, {2'h2, 2'(s), 2'h0, 5'(s + 1), 5'h01});
      wstart;
      chk("setup", 16'h0001 << s, {12'h000, setup_onehot});
      chk("pos", 16'(s + 1), {11'h000, route.positive});
    end
    $display("field test done");
  endtask
  task t_seq;
    logic [1:0] c;
    wr(8'h10, 16'h8001);
    wr(8'h11, 16'h9001);
    wstart;
    c = route.channel;
    wstart;
    chk("pair", (c == 2'h0) ? 16'h0001 : 16'h0004, {12'h000, c, route.channel});
    chk("route setup", {14'h0000, route.channel}, {14'h0000, route.setup});
    wr(8'h10, 16'h0001);
    wr(8'h11, 16'h0001);
    repeat (20) @(posedge clock);
    #1;
    chk("idle", 16'h0000, {15'h0000, active});
    $display("sequence test done");
  endtask
  task t_codes;
    wr(8'h10, 16'h80a1);
    wstart;
    chk("pos code", 16'h0005, {11'h000, route.positive});
    chk("pos valid", 16'h0000, {15'h0000, route.pos_valid});
    chk("neg code", 16'h0001, {11'h000, route.negative});
    chk("neg valid", 16'h0001, {15'h0000, route.neg_valid});
    wr(8'h10, 16'h8224);
    wstart;
    chk("pos valid hi", 16'h0001, {15'h0000, route.pos_valid});
    chk("neg four", 16'h0004, {11'h000, route.negative});
    $display("code test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_fields;
    t_seq;
    t_codes;
    wrap_up;
  end
endmodule

// ==== acc_pkg.sv ====
package acc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CHAN = 4;
  localparam int NUM_SETUP = 4;
  localparam logic [7:0] CHAN_BASE_ADDR = 8'h10;
  localparam logic [7:0] CHAN_LAST_ADDR = 8'h13;
  localparam logic [7:0] SEQ_STATUS_ADDR = 8'h30;
  localparam logic [7:0] SEQ_CTRL_ADDR = 8'h31;
  localparam int ENABLE_POS = 15;
  localparam int RSVD_HI_POS = 14;
  localparam int SETUP_LSB = 12;
  localparam int RSVD_LO_LSB = 10;
  localparam int POS_LSB = 5;
  localparam int NEG_LSB = 0;
  localparam logic [15:0] CHAN_ZERO_RESET = 16'h8001;
  localparam logic [15:0] CHAN_OTHER_RESET = 16'h0001;
  localparam logic [15:0] WRITABLE_MASK = 16'hb3ff;
  localparam logic [4:0] INPUT_CODE_LAST = 5'h04;
  localparam logic [4:0] INPUT_CODE_TEMP_P = 5'h11;
  localparam logic [4:0] INPUT_CODE_REF_N = 5'h16;
  localparam logic [15:0] DWELL_DEFAULT = 16'h0010;

  typedef struct packed {
    logic enable;
    logic rsvd_hi;
    logic [1:0] setup_choice;
    logic [1:0] rsvd_lo;
    logic [4:0] positive_choice;
    logic [4:0] negative_choice;
  } acc_chan_word_t;

  typedef struct packed {
    logic [1:0] channel;
    logic [1:0] setup;
    logic [4:0] positive;
    logic [4:0] negative;
    logic pos_valid;
    logic neg_valid;
  } acc_route_t;
endpackage

// ==== acc_seq_picker.sv ====
`timescale 1ns/1ps
module acc_seq_picker #(
  parameter int NCH = 4
) (
  input wire logic [NCH-1:0] enables,
  input wire logic [1:0] current,
  output logic [1:0] next_chan,
  output logic any_enabled
);
  // round robin: first enabled channel after current, wrapping
  logic [1:0] pick;
  logic found;
  always_comb begin
    pick = current;
    found = 1'b0;
    for (int k = 1; k <= NCH; k++) begin
      if (!found && enables[2'(current + 2'(k))]) begin
        pick = 2'(current + 2'(k));
        found = 1'b1;
      end
    end
  end
  assign next_chan = pick;
  assign any_enabled = |enables;
endmodule
